/* rtl/spm_cfg.svh */
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

// command type codes, upper nibble of the command byte
`define SPM_T_STS 4'h3
`define SPM_T_PWR 4'h4
`define SPM_T_PRD 4'h5
`define SPM_T_ISW 4'h6
`define SPM_T_ISR 4'h7
`define SPM_T_IFW 4'h8
`define SPM_T_IFR 4'h9
`define SPM_T_BAD0 4'ha
`define SPM_T_BAD1 4'hc
`define SPM_T_BAD2 4'he

// command byte layout
`define SPM_CMD_TYPE_HI 7
`define SPM_CMD_TYPE_LO 4
`define SPM_CMD_CODE_HI 3
`define SPM_CMD_CODE_LO 2
`define SPM_CMD_ZERO 2'h0

// memory limits
`define SPM_PWR_MAX 6'd32
`define SPM_PWR_OVF 6'd33
`define SPM_STS_BYTES 8'h02
`define SPM_DUMMY 8'h00

// status word bit positions and reset values
`define SPM_SW_ERR 0
`define SPM_SW_DEFER 1
`define SPM_SW_LINK 2
`define SPM_SW_RST 16'h0000

// timing
`define SPM_CLK_NS 5
`define SPM_SCLK_HALF_NS 32
`define SPM_HALF_CYC ((`SPM_SCLK_HALF_NS + `SPM_CLK_NS - 1) / `SPM_CLK_NS)

// host register byte offsets
`define SPM_A_CMD 5'h00
`define SPM_A_DATA 5'h04
`define SPM_A_IRQS 5'h08
`define SPM_A_IRQM 5'h0c
`define SPM_A_STAT 5'h10

// host command register fields
`define SPM_F_GO 31
`define SPM_F_BUSY 31

// host interrupt bits
`define SPM_IRQ_DONE 0
`define SPM_IRQ_RX 1
`define SPM_IRQ_REF 2
`define SPM_IRQ_RST 3'h0

`endif

/* rtl/spm_pkg.sv */
package spm_pkg;
	typedef logic [7:0] spm_byte_t;
	typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOAD, H_LOW, H_HIGH, H_TAIL, H_GAP} spm_hst_t;
endpackage

/* rtl/spm_if.sv */
`timescale 1ns/1ps
interface spm_if;
	logic sclk;
	logic ss_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic miso_line;
	// undriven data line floats high through the pull-up
	assign miso_line = miso_oe ? miso : 1'b1;
	modport dev (input sclk, input ss_n, input mosi, output miso, output miso_oe);
	modport host (output sclk, output ss_n, output mosi, input miso_line);
endinterface

/* rtl/spm_dev.sv */
`timescale 1ns/1ps
// Summary of operation
// RULE_01: status read returns low then high byte
// RULE_02: respond only when select code matches
// RULE_03: port writes touch only input-configured ports
// RULE_04: port write address auto-increments, wraps 255
// RULE_05: over 32 bytes flags error, discards all
// RULE_06: unlinked: commit at select release
// RULE_07: linked: commit at four link events
// RULE_08: frames pre-empt commit, deferred flag tracks
// RULE_09: host waits until deferred flag clears
// RULE_10: port read returns byte per dummy
// RULE_11: port read address wraps, unlimited length
// RULE_12: data line released during command, address
// RULE_13: setting write wraps at 31, overwrites
// RULE_14: setting read wraps at 31
// RULE_15: flag write wraps at 31, overwrites
// RULE_16: flag read wraps at 31
// RULE_17: host never sends reserved command types
// RULE_18: select release restarts byte framing
`include "spm_cfg.svh"
module spm_dev import spm_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic en_i,
	// serial link
	spm_if.dev spi,
	// configuration
	input wire logic [1:0] slave_select_code_i,
	input wire logic [255:0] port_direction_setting_i,
	// network side
	input wire logic link_connected_flag_i,
	input wire logic frame_busy_i,
	input wire logic frame_other_i,
	input wire logic frame_bcast_own_i,
	input wire logic response_done_i,
	input wire logic link_timeout_i,
	input wire logic net_wr_i,
	input wire logic [7:0] net_addr_i,
	input wire logic [7:0] net_data_i,
	// status
	input wire logic [15:0] status_ext_i,
	input wire logic err_clear_i,
	output logic [15:0] status_word_o,
	output logic irq_o
);
	logic [1:0] sclk_s, ss_s, mosi_s;
	logic sclk_d, ss_d;
	logic rise, fall, sel, ss_rise, byte_done;
	logic [2:0] bit_reg;
	logic [1:0] idx_reg;
	logic [6:0] rx_sh;
	spm_byte_t rx_byte, tx_reg, addr_reg, pend_addr, commit_a;
	logic [3:0] cmd_reg;
	logic act_reg, tx_ok, miso_reg, oe_reg;
	spm_byte_t port_mem [256];
	spm_byte_t iset_mem [32];
	spm_byte_t iflg_mem [32];
	spm_byte_t pend_data [32];
	logic [5:0] pend_cnt;
	logic [4:0] ci_reg;
	logic pend_reg, commit_reg, defer_reg, err_reg, commit_go, commit_wr, pwr_end;

	function automatic logic is_read(input logic [3:0] t);
		is_read = (t == `SPM_T_STS) || (t == `SPM_T_PRD) || (t == `SPM_T_ISR) || (t == `SPM_T_IFR);
	endfunction

	// port memory wraps at 255, interrupt memories at 31
	function automatic spm_byte_t next_addr(input logic [3:0] t, input spm_byte_t a);
		if (t == `SPM_T_PWR || t == `SPM_T_PRD) begin
			next_addr = a + 8'h01; // see RULE_04 // see RULE_11
		end else begin
			next_addr = {3'h0, a[4:0] + 5'h01}; // see RULE_13 // see RULE_14 // see RULE_15 // see RULE_16
		end
	endfunction

	function spm_byte_t rd_mem(input logic [3:0] t, input spm_byte_t a);
		case (t)
			`SPM_T_PRD: rd_mem = port_mem[a]; // see RULE_10
			`SPM_T_ISR: rd_mem = iset_mem[a[4:0]]; // see RULE_14
			`SPM_T_IFR: rd_mem = iflg_mem[a[4:0]]; // see RULE_16
			default: rd_mem = `SPM_DUMMY;
		endcase
	endfunction

	// pins cross into this clock through two flops each
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			sclk_s <= 2'h0;
			ss_s <= 2'h3;
			mosi_s <= 2'h0;
			sclk_d <= 1'b0;
			ss_d <= 1'b1;
		end else if (en_i) begin
			sclk_s <= {sclk_s[0], spi.sclk};
			ss_s <= {ss_s[0], spi.ss_n};
			mosi_s <= {mosi_s[0], spi.mosi};
			sclk_d <= sclk_s[1];
			ss_d <= ss_s[1];
		end
	end

	assign sel = ~ss_s[1];
	assign rise = sel & sclk_s[1] & ~sclk_d;
	assign fall = sel & ~sclk_s[1] & sclk_d;
	assign ss_rise = ss_s[1] & ~ss_d;
	assign byte_done = rise & (bit_reg == 3'h7);
	assign rx_byte = {rx_sh, mosi_s[1]};

	// framing: position restarts whenever select is released
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			bit_reg <= 3'h0;
			idx_reg <= 2'h0;
			rx_sh <= 7'h00;
		end else if (en_i) begin
			if (!sel) begin
				bit_reg <= 3'h0; // see RULE_18
				idx_reg <= 2'h0; // see RULE_18
			end else if (rise) begin
				bit_reg <= bit_reg + 3'h1;
				rx_sh <= rx_byte[6:0];
				if (bit_reg == 3'h7 && idx_reg != 2'h2) begin
					idx_reg <= idx_reg + 2'h1;
				end
			end
		end
	end

	// command decode; reserved and foreign commands leave the device silent
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cmd_reg <= 4'h0;
			act_reg <= 1'b0;
		end else if (en_i) begin
			if (!sel) begin
				act_reg <= 1'b0;
			end else if (byte_done && idx_reg == 2'h0) begin
				cmd_reg <= rx_byte[`SPM_CMD_TYPE_HI:`SPM_CMD_TYPE_LO];
				act_reg <= (rx_byte[`SPM_CMD_CODE_HI:`SPM_CMD_CODE_LO] == slave_select_code_i)
					&& (rx_byte[1:0] == `SPM_CMD_ZERO)
					&& (rx_byte[7:4] >= `SPM_T_STS) && (rx_byte[7:4] <= `SPM_T_IFR); // see RULE_02
			end
		end
	end

	// address pointer and outgoing byte; reads keep the pointer one ahead
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			addr_reg <= 8'h00;
			tx_reg <= 8'h00;
			tx_ok <= 1'b0;
		end else if (en_i) begin
			if (!sel) begin
				tx_ok <= 1'b0;
			end else if (byte_done) begin
				tx_ok <= 1'b0;
				if (idx_reg == 2'h0) begin
					tx_reg <= status_word_o[7:0]; // see RULE_01
					tx_ok <= (rx_byte[7:4] == `SPM_T_STS)
						&& (rx_byte[3:2] == slave_select_code_i) && (rx_byte[1:0] == `SPM_CMD_ZERO);
				end else if (act_reg && idx_reg == 2'h1) begin
					if (cmd_reg == `SPM_T_STS) begin
						tx_reg <= status_word_o[15:8]; // see RULE_01
						tx_ok <= 1'b1;
					end else begin
						addr_reg <= is_read(cmd_reg) ? next_addr(cmd_reg, rx_byte) : rx_byte;
						tx_reg <= rd_mem(cmd_reg, rx_byte);
						tx_ok <= is_read(cmd_reg);
					end
				end else if (act_reg && cmd_reg != `SPM_T_STS) begin
					addr_reg <= next_addr(cmd_reg, addr_reg);
					tx_reg <= rd_mem(cmd_reg, addr_reg); // see RULE_11
					tx_ok <= is_read(cmd_reg);
				end
			end else if (fall) begin
				tx_reg <= {tx_reg[6:0], 1'b0};
			end
		end
	end

	// line stays released through command and address bytes
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			miso_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else if (en_i) begin
			if (!sel) begin
				oe_reg <= 1'b0;
			end else if (fall) begin
				miso_reg <= tx_reg[7];
				oe_reg <= tx_ok; // see RULE_12
			end
		end
	end
	assign spi.miso = miso_reg;
	assign spi.miso_oe = oe_reg;

	// interrupt memories take each byte as it arrives
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < 32; i++) begin
				iset_mem[i] <= 8'h00;
				iflg_mem[i] <= 8'h00;
			end
		end else if (en_i && byte_done && act_reg && idx_reg == 2'h2) begin
			if (cmd_reg == `SPM_T_ISW) begin
				iset_mem[addr_reg[4:0]] <= rx_byte; // see RULE_13
			end
			if (cmd_reg == `SPM_T_IFW) begin
				iflg_mem[addr_reg[4:0]] <= rx_byte; // see RULE_15
			end
		end
	end

	// port write data waits in a staging buffer until a commit point
	assign pwr_end = ss_rise & act_reg & (cmd_reg == `SPM_T_PWR) & ~pend_reg;
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pend_cnt <= 6'h00;
			pend_addr <= 8'h00;
			for (int i = 0; i < 32; i++) begin
				pend_data[i] <= 8'h00;
			end
		end else if (en_i && byte_done && act_reg && cmd_reg == `SPM_T_PWR && !pend_reg) begin
			if (idx_reg == 2'h1) begin
				pend_addr <= rx_byte;
				pend_cnt <= 6'h00;
			end else if (idx_reg == 2'h2) begin
				if (pend_cnt < `SPM_PWR_MAX) begin
					pend_data[pend_cnt[4:0]] <= rx_byte; // see RULE_04
					pend_cnt <= pend_cnt + 6'h01;
				end else begin
					pend_cnt <= `SPM_PWR_OVF; // see RULE_05
				end
			end
		end
	end

	assign commit_go = pend_reg & ~commit_reg & (~link_connected_flag_i // see RULE_06
		| frame_other_i | frame_bcast_own_i | response_done_i | link_timeout_i); // see RULE_07
	assign commit_wr = commit_reg & ~frame_busy_i; // see RULE_08
	assign commit_a = pend_addr + {3'h0, ci_reg};

	// commit sequencer: one byte per cycle, stalls while a frame is handled
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pend_reg <= 1'b0;
			commit_reg <= 1'b0;
			ci_reg <= 5'h00;
		end else if (en_i) begin
			if (pwr_end && pend_cnt != 6'h00 && pend_cnt <= `SPM_PWR_MAX) begin
				pend_reg <= 1'b1;
			end
			if (commit_go) begin
				commit_reg <= 1'b1;
				ci_reg <= 5'h00;
			end else if (commit_wr) begin
				ci_reg <= ci_reg + 5'h01;
				if ({1'b0, ci_reg} == pend_cnt - 6'h01) begin
					commit_reg <= 1'b0;
					pend_reg <= 1'b0;
				end
			end
		end
	end

	// network writes win the memory port over a commit
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < 256; i++) begin
				port_mem[i] <= 8'h00;
			end
		end else if (en_i) begin
			if (net_wr_i) begin
				port_mem[net_addr_i] <= net_data_i;
			end else if (commit_wr && port_direction_setting_i[commit_a]) begin
				port_mem[commit_a] <= pend_data[ci_reg]; // see RULE_03
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			defer_reg <= 1'b0;
		end else if (en_i) begin
			if (commit_reg && frame_busy_i) begin
				defer_reg <= 1'b1; // see RULE_08
			end else if (commit_wr && {1'b0, ci_reg} == pend_cnt - 6'h01) begin
				defer_reg <= 1'b0; // see RULE_08
			end
		end
	end

	// error flag: a new overflow beats a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			err_reg <= 1'b0;
		end else if (en_i) begin
			if (pwr_end && pend_cnt > `SPM_PWR_MAX) begin
				err_reg <= 1'b1; // see RULE_05
			end else if (err_clear_i) begin
				err_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			status_word_o <= `SPM_SW_RST;
		end else if (en_i) begin
			status_word_o <= status_ext_i;
			status_word_o[`SPM_SW_ERR] <= err_reg;
			status_word_o[`SPM_SW_DEFER] <= defer_reg;
			status_word_o[`SPM_SW_LINK] <= link_connected_flag_i;
		end
	end
	assign irq_o = err_reg;
endmodule // spm_dev

/* rtl/spm_host.sv */
`timescale 1ns/1ps
`include "spm_cfg.svh"
module spm_host import spm_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic en_i,
	// avalon slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	// serial link
	spm_if.host spi
);
	spm_hst_t st_reg;
	logic [1:0] miso_s;
	logic [7:0] div_reg, cnt_reg;
	logic [2:0] bit_reg;
	logic [1:0] bidx_reg;
	logic [3:0] typ_reg;
	logic [1:0] code_reg;
	spm_byte_t addr_reg, sh_reg, rx_sh, txh_reg, rxh_reg;
	logic [15:0] last_sts;
	logic [2:0] irqs_reg, irqm_reg, irq_set;
	logic tx_full, rx_hold, ack_reg, stall, do_wr, do_rd, go_ok, go_req, half, wr_type;
	logic sclk_reg, ss_reg;

	assign half = (div_reg == 8'(`SPM_HALF_CYC - 1));
	assign wr_type = (typ_reg == `SPM_T_PWR) || (typ_reg == `SPM_T_ISW) || (typ_reg == `SPM_T_IFW);
	assign stall = (avs_address_i == `SPM_A_DATA) & ((avs_write_i & tx_full) | (avs_read_i & ~rx_hold));
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
	assign do_wr = avs_write_i & ack_reg;
	assign do_rd = avs_read_i & ack_reg;
	assign go_req = do_wr & (avs_address_i == `SPM_A_CMD) & avs_writedata_i[`SPM_F_GO];
	assign go_ok = (st_reg == H_IDLE)
		&& (avs_writedata_i[3:0] != `SPM_T_BAD0) && (avs_writedata_i[3:0] != `SPM_T_BAD1)
		&& (avs_writedata_i[3:0] != `SPM_T_BAD2) // see RULE_17
		&& (!last_sts[`SPM_SW_DEFER] || avs_writedata_i[3:0] == `SPM_T_STS); // see RULE_09

	// answer one cycle after the request unless the data port must wait
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ack_reg <= 1'b0;
			avs_readdata_o <= 32'h0000_0000;
		end else if (en_i) begin
			ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg & ~stall;
			case (avs_address_i)
				`SPM_A_CMD: avs_readdata_o <= {st_reg != H_IDLE, 7'h00, cnt_reg, addr_reg, 2'h0,
					code_reg, typ_reg};
				`SPM_A_DATA: avs_readdata_o <= {24'h000000, rxh_reg};
				`SPM_A_IRQS: avs_readdata_o <= {29'h0, irqs_reg};
				`SPM_A_IRQM: avs_readdata_o <= {29'h0, irqm_reg};
				`SPM_A_STAT: avs_readdata_o <= {16'h0000, last_sts};
				default: avs_readdata_o <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			miso_s <= 2'h3;
		end else if (en_i) begin
			miso_s <= {miso_s[0], spi.miso_line};
		end
	end

	// one-byte holding registers in each direction give the back-pressure
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			tx_full <= 1'b0;
			txh_reg <= 8'h00;
		end else if (en_i) begin
			if (do_wr && avs_address_i == `SPM_A_DATA) begin
				tx_full <= 1'b1;
				txh_reg <= avs_writedata_i[7:0];
			end else if (st_reg == H_LOAD && bidx_reg == 2'h2 && wr_type && cnt_reg != 8'h00) begin
				tx_full <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			irqs_reg <= `SPM_IRQ_RST;
			irqm_reg <= `SPM_IRQ_RST;
		end else if (en_i) begin
			irqs_reg <= (irqs_reg & ~((do_wr && avs_address_i == `SPM_A_IRQS) ? avs_writedata_i[2:0]
				: 3'h0)) | irq_set;
			if (do_wr && avs_address_i == `SPM_A_IRQM) begin
				irqm_reg <= avs_writedata_i[2:0];
			end
		end
	end
	assign irq_o = |(irqs_reg & irqm_reg);

	always_comb begin
		irq_set = 3'h0;
		irq_set[`SPM_IRQ_DONE] = (st_reg == H_GAP) & half;
		irq_set[`SPM_IRQ_RX] = (st_reg == H_HIGH) & half & (bit_reg == 3'h7) & (bidx_reg == 2'h2)
			& ~wr_type;
		irq_set[`SPM_IRQ_REF] = go_req & ~go_ok;
	end

	// sequencer: mode 0, data out at the low edge, sampled late in the high phase
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_reg <= H_IDLE;
			div_reg <= 8'h00;
			bit_reg <= 3'h0;
			bidx_reg <= 2'h0;
			typ_reg <= 4'h0;
			code_reg <= 2'h0;
			addr_reg <= 8'h00;
			cnt_reg <= 8'h00;
			sh_reg <= 8'h00;
			rx_sh <= 8'h00;
			rxh_reg <= 8'h00;
			rx_hold <= 1'b0;
			last_sts <= `SPM_SW_RST;
			sclk_reg <= 1'b0;
			ss_reg <= 1'b1;
		end else if (en_i) begin
			div_reg <= half ? 8'h00 : div_reg + 8'h01;
			if (do_rd && avs_address_i == `SPM_A_DATA) begin
				rx_hold <= 1'b0;
			end
			case (st_reg)
				H_IDLE: begin
					div_reg <= 8'h00;
					if (go_req && go_ok) begin
						typ_reg <= avs_writedata_i[3:0];
						code_reg <= avs_writedata_i[5:4];
						addr_reg <= avs_writedata_i[15:8];
						cnt_reg <= (avs_writedata_i[3:0] == `SPM_T_STS) ? `SPM_STS_BYTES
							: avs_writedata_i[23:16]; // see RULE_01
						bidx_reg <= 2'h0;
						ss_reg <= 1'b0;
						st_reg <= H_LEAD;
					end
				end
				H_LEAD: begin
					if (half) begin
						st_reg <= H_LOAD;
					end
				end
				H_LOAD: begin
					div_reg <= 8'h00;
					bit_reg <= 3'h0;
					if (bidx_reg == 2'h0) begin
						sh_reg <= {typ_reg, code_reg, `SPM_CMD_ZERO}; // see RULE_02
						st_reg <= H_LOW;
					end else if (bidx_reg == 2'h1) begin
						sh_reg <= addr_reg; // see RULE_04 // see RULE_10
						st_reg <= H_LOW;
					end else if (cnt_reg == 8'h00) begin
						st_reg <= H_TAIL;
					end else if (wr_type ? tx_full : ~rx_hold) begin
						sh_reg <= wr_type ? txh_reg : `SPM_DUMMY; // see RULE_12
						st_reg <= H_LOW;
					end
				end
				H_LOW: begin
					if (half) begin
						sclk_reg <= 1'b1;
						st_reg <= H_HIGH;
					end
				end
				H_HIGH: begin
					if (half) begin
						sclk_reg <= 1'b0;
						rx_sh <= {rx_sh[6:0], miso_s[1]};
						if (bit_reg == 3'h7) begin
							st_reg <= H_LOAD;
							if (bidx_reg == 2'h2) begin
								cnt_reg <= cnt_reg - 8'h01;
								if (!wr_type) begin
									rxh_reg <= {rx_sh[6:0], miso_s[1]};
									rx_hold <= 1'b1;
								end
								if (typ_reg == `SPM_T_STS && cnt_reg == `SPM_STS_BYTES) begin
									last_sts[7:0] <= {rx_sh[6:0], miso_s[1]};
								end else if (typ_reg == `SPM_T_STS) begin
									last_sts[15:8] <= {rx_sh[6:0], miso_s[1]};
								end
							end else begin
								// status has no address byte
								bidx_reg <= (typ_reg == `SPM_T_STS) ? 2'h2 : bidx_reg + 2'h1;
							end
						end else begin
							bit_reg <= bit_reg + 3'h1;
							sh_reg <= {sh_reg[6:0], 1'b0};
							st_reg <= H_LOW;
						end
					end
				end
				H_TAIL: begin
					if (half) begin
						ss_reg <= 1'b1;
						st_reg <= H_GAP;
					end
				end
				H_GAP: begin
					if (half) begin
						st_reg <= H_IDLE;
					end
				end
				default: st_reg <= H_IDLE;
			endcase
		end
	end

	assign spi.sclk = sclk_reg;
	assign spi.ss_n = ss_reg;
	assign spi.mosi = sh_reg[7];
endmodule // spm_host

/* tb/spm_properties.sv */
`timescale 1ns/1ps
module spm_properties (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// serial link
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic miso_line
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	property p_oe_drop;
		$rose(ss_n) |-> ##[1:5] !miso_oe;
	endproperty
	a_oe_drop: assert property (p_oe_drop)
		else $error("data line still driven after select release");

	property p_oe_start;
		$rose(miso_oe) |-> !sclk && !ss_n;
	endproperty
	a_oe_start: assert property (p_oe_start)
		else $error("data line driven outside a low clock phase");

	property p_miso_shift;
		miso_oe && $past(miso_oe) && $changed(miso) |-> !sclk;
	endproperty
	a_miso_shift: assert property (p_miso_shift)
		else $error("read data changed while serial clock high");

	property p_mosi_shift;
		!ss_n && $changed(mosi) |-> !sclk;
	endproperty
	a_mosi_shift: assert property (p_mosi_shift)
		else $error("host data changed while serial clock high");

	property p_sclk_idle;
		ss_n && $past(ss_n) |-> !sclk;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle)
		else $error("serial clock moves outside a frame");

	property p_lead;
		$fell(ss_n) |-> !sclk [*7];
	endproperty
	a_lead: assert property (p_lead)
		else $error("serial clock too soon after select");

	property p_gap;
		$rose(ss_n) |-> ss_n [*2];
	endproperty
	a_gap: assert property (p_gap)
		else $error("select gap too short");

	property p_half;
		$rose(sclk) |-> sclk [*7] ##1 !sclk;
	endproperty
	a_half: assert property (p_half)
		else $error("serial clock high phase not seven cycles");

	property p_pullup;
		!miso_oe |-> miso_line;
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("released data line not high");
endmodule // spm_properties

/* tb/spm_bench.sv */
`timescale 1ns/1ps
`include "spm_cfg.svh"
module spm_bench import spm_pkg::*;;
	logic clk_i = 0;
	logic nrst_i = 0;
	logic [4:0] adr;
	logic rd, wr, wreq, hirq, dirq, lnk, fbusy, eclr;
	logic [3:0] ev;
	logic [31:0] wdat, rdat, q;
	logic [15:0] sw, ext;
	logic [1:0] code;
	logic [255:0] pdir;
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;
	spm_byte_t tx[40], rx[8], ex[4];
	always #2.5 clk_i = ~clk_i;
	spm_if u_spm_if();
	spm_host u_spm_host(.clk_i(clk_i), .nrst_i(nrst_i), .en_i(1'b1), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .irq_o(hirq), .spi(u_spm_if));
	spm_dev u_spm_dev(.clk_i(clk_i), .nrst_i(nrst_i), .en_i(1'b1), .spi(u_spm_if),
		.slave_select_code_i(code), .port_direction_setting_i(pdir), .link_connected_flag_i(lnk),
		.frame_busy_i(fbusy), .frame_other_i(ev[0]), .frame_bcast_own_i(ev[1]),
		.response_done_i(ev[2]), .link_timeout_i(ev[3]), .net_wr_i(1'b0), .net_addr_i(8'h00),
		.net_data_i(8'h00), .status_ext_i(ext), .err_clear_i(eclr), .status_word_o(sw),
		.irq_o(dirq));
	spm_properties u_spm_properties(.clk_i(clk_i), .nrst_i(nrst_i), .sclk(u_spm_if.sclk),
		.ss_n(u_spm_if.ss_n), .mosi(u_spm_if.mosi), .miso(u_spm_if.miso),
		.miso_oe(u_spm_if.miso_oe), .miso_line(u_spm_if.miso_line));

	task finish_test;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ceiling well above the roughly 23k cycles the sequence needs
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			error_cnt++;
			finish_test();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// request held until waitrequest is seen low, released right after
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_i);
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		do @(posedge clk_i); while (wreq !== 1'b0);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task xfer(input logic [3:0] t, input logic [1:0] c, input logic [7:0] a, input int n);
		bus(1, `SPM_A_CMD, {1'b1, 7'h00, 8'(n), a, 2'b00, c, t});
		for (int i = 0; i < n; i++) begin
			// status bytes also land in the data port and stall the engine until popped
			if (t[0]) begin
				bus(0, `SPM_A_DATA, 32'h0);
				rx[i] = q[7:0];
			end else if (!t[0])
				bus(1, `SPM_A_DATA, {24'h0, tx[i]});
		end
		do bus(0, `SPM_A_CMD, 32'h0); while (q[`SPM_F_BUSY] !== 1'b0);
	endtask

	task pulse(input logic [3:0] e);
		@(posedge clk_i);
		ev <= e;
		@(posedge clk_i);
		ev <= 4'h0;
		repeat (6) @(posedge clk_i);
	endtask

	initial begin
		{adr, rd, wr, wdat, lnk, fbusy, eclr, ev} = '0;
		code = 2'h1;
		pdir = '1;
		pdir[255] = 1'b0;
		ext = 16'h5a38;
		repeat (8) @(posedge clk_i);
		nrst_i <= 1'b1;
		bus(0, 5'h14, 32'h0);
		chk(q, 32'h0);
		xfer(`SPM_T_STS, code, 8'h00, 2);
		chk({rx[1], rx[0]}, 16'h5a38);
		bus(0, `SPM_A_STAT, 32'h0);
		chk(q[15:0], 16'h5a38);
		$display("status test done");
		xfer(`SPM_T_PRD, code, 8'hfe, 4);
		for (int i = 0; i < 4; i++) begin
			ex[i] = (i == 1) ? rx[i] : 8'h30 + 8'(i);
			tx[i] = 8'h30 + 8'(i);
		end
		xfer(`SPM_T_PWR, code, 8'hfe, 4);
		for (int i = 0; i < 4; i++)
			tx[i] = 8'hc0 + 8'(i);
		xfer(`SPM_T_PWR, code ^ 2'h3, 8'hfe, 4);
		xfer(`SPM_T_PRD, code, 8'hfe, 4);
		for (int i = 0; i < 4; i++)
			chk(rx[i], ex[i]);
		for (int i = 0; i < 33; i++)
			tx[i] = 8'h77;
		xfer(`SPM_T_PWR, code, 8'hfe, 33);
		chk(sw[`SPM_SW_ERR], 1'b1);
		chk(dirq, 1'b1);
		xfer(`SPM_T_PRD, code, 8'hfe, 4);
		for (int i = 0; i < 4; i++)
			chk(rx[i], ex[i]);
		@(posedge clk_i);
		eclr <= 1'b1;
		@(posedge clk_i);
		eclr <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk(dirq, 1'b0);
		$display("unlinked write test done");
		lnk <= 1'b1;
		xfer(`SPM_T_PRD, code, 8'h10, 1);
		ex[0] = rx[0];
		for (int e = 0; e < 4; e++) begin
			tx[0] = 8'h40 + 8'(e);
			xfer(`SPM_T_PWR, code, 8'h10, 1);
			xfer(`SPM_T_PRD, code, 8'h10, 1);
			chk(rx[0], ex[0]);
			pulse(4'h1 << e);
			xfer(`SPM_T_PRD, code, 8'h10, 1);
			chk(rx[0], tx[0]);
			ex[0] = tx[0];
		end
		fbusy <= 1'b1;
		tx[0] = 8'h55;
		xfer(`SPM_T_PWR, code, 8'h10, 1);
		pulse(4'h4);
		xfer(`SPM_T_STS, code, 8'h00, 2);
		bus(0, `SPM_A_STAT, 32'h0);
		chk(q[15:0], 16'h5a3e);
		fbusy <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk(sw[`SPM_SW_DEFER], 1'b0);
		xfer(`SPM_T_STS, code, 8'h00, 2);
		bus(0, `SPM_A_STAT, 32'h0);
		chk(q[15:0], 16'h5a3c);
		xfer(`SPM_T_PRD, code, 8'h10, 1);
		chk(rx[0], 8'h55);
		$display("linked commit test done");
		// start at 31 so both the wrap and the overwrite show in three bytes
		for (int m = 0; m < 2; m++) begin
			for (int i = 0; i < 33; i++)
				tx[i] = 8'h80 + 8'(i) + 8'(m * 64);
			xfer(m ? `SPM_T_IFW : `SPM_T_ISW, code, 8'h1f, 33);
			xfer(m ? `SPM_T_IFR : `SPM_T_ISR, code, 8'h1f, 3);
			chk(rx[0], tx[32]);
			chk(rx[1], tx[1]);
			chk(rx[2], tx[2]);
		end
		$display("interrupt memory test done");
		bus(1, `SPM_A_IRQM, 32'h0);
		bus(1, `SPM_A_IRQS, 32'h7);
		xfer(`SPM_T_BAD0, code, 8'h00, 0);
		bus(0, `SPM_A_IRQS, 32'h0);
		chk(q[`SPM_IRQ_REF], 1'b1);
		chk(hirq, 1'b0);
		bus(1, `SPM_A_IRQM, 32'h4);
		@(posedge clk_i);
		chk(hirq, 1'b1);
		bus(1, `SPM_A_IRQS, 32'h4);
		@(posedge clk_i);
		chk(hirq, 1'b0);
		$display("host interrupt test done");
		finish_test();
	end
endmodule // spm_bench
